// *** inc/crce_pkg.sv ***
/*
  crce_pkg: register indices, field positions, reset values and engine
  states for the checksum engine and its neighbouring scanner registers.
  assumes a 32-bit apb slave where byte address = 4 * register index.
*/
package crce_pkg;

  // bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  localparam int WORD_W = 16;
  localparam int FIELD_W = 4;
  localparam int SCAN_ADDR_W = 24;
  localparam int CNT_W = 5;

  // register indices as printed, byte address is four times these
  localparam logic [IDX_W-1:0] IDX_SCAN_START = 14'hf49;
  localparam logic [IDX_W-1:0] IDX_SCAN_END = 14'hf4c;
  localparam logic [IDX_W-1:0] IDX_SCAN_CTRL = 14'hf4f;
  localparam logic [IDX_W-1:0] IDX_SCAN_TRIG = 14'hf50;
  localparam logic [IDX_W-1:0] IDX_DATA = 14'hf74;
  localparam logic [IDX_W-1:0] IDX_ACC = 14'hf76;
  localparam logic [IDX_W-1:0] IDX_SHIFT = 14'hf78;
  localparam logic [IDX_W-1:0] IDX_TAPS = 14'hf7a;
  localparam logic [IDX_W-1:0] IDX_CTRL = 14'hf7c;
  localparam logic [IDX_W-1:0] IDX_LEN = 14'hf7d;

  // checksum_control field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_GO_BIT = 6;
  localparam int CTRL_BUSY_BIT = 5;
  localparam int CTRL_ZERO_AUGMENT_SELECT_BIT = 4;
  localparam int CTRL_SHIFT_DIRECTION_SELECT_BIT = 1;
  localparam int CTRL_FULL_BIT = 0;

  // checksum_lengths field positions
  localparam int LEN_DATA_LSB = 4;
  localparam int LEN_POLY_LSB = 0;

  // scanner control: writable bits and reset image (invalid reads one)
  localparam logic [7:0] SCAN_CTRL_WMASK = 8'hcb;
  localparam logic [7:0] SCAN_CTRL_RST = 8'h10;
  localparam logic [7:0] SCAN_TRIG_MASK = 8'h0f;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic [WORD_W-1:0] ACC_RST = 16'h0000;
  localparam logic [WORD_W-1:0] SHIFT_RST = 16'h0000;
  localparam logic [WORD_W-1:0] DATA_RST = 16'h0000;
  localparam logic [SCAN_ADDR_W-1:0] SCAN_ADDR_RST = 24'h000000;
  localparam logic TAP_BIT0 = 1'b1;

  // engine states
  typedef enum logic [1:0] {ENG_OFF, ENG_IDLE, ENG_SHIFT} crce_eng_type;

endpackage

// *** logic/crce_step.sv ***
/*
  crce_step: one combinational step of the checksum accumulator.
  assumes the caller forces tap bit zero to one and supplies lengths
  that fit the four-bit field.
*/
`timescale 1ns/1ps

module crce_step #(
  parameter int W = 16
) (
  input wire logic [W-1:0] acc,
  input wire logic [W-1:0] taps,
  input wire logic [3:0] poly_width_minus_one,
  input wire logic din,
  input wire logic zero_augment_select,
  output logic [W-1:0] acc_next
);

  logic [W-1:0] mask;
  logic [W-1:0] shifted;
  logic msb;
  logic fb;

  // refuse widths the four-bit length field cannot address
  if (W != 16) begin : g_chk
    $error("crce_step width must be 16");
  end

  // active accumulator bits are 0 .. poly_width_minus_one
  for (genvar i = 0; i < W; i++) begin : g_mask
    assign mask[i] = (i <= int'(poly_width_minus_one));
  end

  // direct form with zero augment folds the data bit into the feedback
  always_comb begin
    msb = acc[poly_width_minus_one];
    fb = zero_augment_select ? (msb ^ din) : msb;
    shifted = {acc[W-2:0], zero_augment_select ? 1'b0 : din};
    acc_next = (shifted ^ (fb ? taps : '0)) & mask;
  end

endmodule

// *** logic/crce_top.sv ***
/*
  crce_top: programmable checksum engine register set on apb, with the
  serial shifter, accumulator and the passive scanner register block.
  assumes an apb master on REF_CLK and a scanner that watches CRC_READY.
*/
// Summary of operation
// - enable set releases engine from internal reset
// - enable clear holds engine off and quiet
// - start bit runs shifter, clear stops it
// - busy reads one while shifting or pending
// - busy zero only when shifter fully drained or engine disabled
// - zero augment bit selects augmented calculation
// - direction bit picks lsb first or msb
// - full flag set while data word waits
// - full flag clears when word enters shifter
// - data length field plus one bits shifted
// - poly length plus one sizes accumulator
// - input data register sixteen bits read write
// - accumulator read write, resets to zero
// - accumulator bytes load and read checksum bytes
// - shifter register read only, resets zero
// - tap bit zero reads one, others enable
`timescale 1ns/1ps

module crce_top #(
  parameter int WORD_W = 16
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [crce_pkg::ADDR_W-1:0] PADDR,
  input wire logic [crce_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [crce_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CRC_BUSY,
  output logic CRC_READY
);
  import crce_pkg::*;

  // refuse a word width the length fields cannot describe
  if (WORD_W != crce_pkg::WORD_W) begin : g_chk
    $error("crce_top word width must be 16");
  end

  // bus state
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;

  // software registers
  logic en_q, en_d;
  logic go_q, go_d;
  logic zero_augment_select_q, zero_augment_select_d;
  logic shift_direction_select_q, shift_direction_select_d;
  logic [7:0] len_q, len_d;
  logic [WORD_W-1:0] data_q, data_d;
  logic [WORD_W-1:0] acc_q, acc_d;
  logic [WORD_W-1:1] taps_q, taps_d;
  logic [SCAN_ADDR_W-1:0] scan_start_q, scan_start_d;
  logic [SCAN_ADDR_W-1:0] scan_end_q, scan_end_d;
  logic [7:0] scan_ctrl_q, scan_ctrl_d;
  logic [7:0] scan_trig_q, scan_trig_d;

  // engine state
  crce_eng_type state_q, state_d;
  logic full_q, full_d;
  logic [WORD_W-1:0] shifter_q, shifter_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic ready_q, ready_d;

  // decode and helpers
  logic access;
  logic wr_fire;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic hit;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wr_merged;
  logic [3:0] data_width_minus_one;
  logic [3:0] poly_width_minus_one;
  logic [WORD_W-1:0] dmask;
  logic [WORD_W-1:0] taps_full;
  logic in_bit;
  logic [WORD_W-1:0] acc_step;

  // byte lane merge of a write into an old register image
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // field views and request qualifiers
  assign data_width_minus_one = len_q[LEN_DATA_LSB +: FIELD_W];
  assign poly_width_minus_one = len_q[LEN_POLY_LSB +: FIELD_W];
  assign taps_full = {taps_q, TAP_BIT0};
  assign access = PSEL && PENABLE;
  assign wr_fire = access && PWRITE && pready_q;
  assign idx = PADDR[ADDR_W-1:2];
  assign aligned = (PADDR[1:0] == 2'b00);
  assign wr_merged = lane_merge(rd_word, PWDATA, PSTRB); // old image of the addressed register

  // live data bits are 0 .. data_width_minus_one
  for (genvar i = 0; i < WORD_W; i++) begin : g_dmask
    assign dmask[i] = (i <= int'(data_width_minus_one));
  end

  // next bit out of the shifter, lsb first or msb first
  assign in_bit = shift_direction_select_q ? shifter_q[0] : shifter_q[data_width_minus_one];

  crce_step #(
    .W(WORD_W)
  ) u_step (
    .acc(acc_q),
    .taps(taps_full),
    .poly_width_minus_one(poly_width_minus_one),
    .din(in_bit),
    .zero_augment_select(zero_augment_select_q),
    .acc_next(acc_step)
  );

  // read image and address decode
  always_comb begin
    rd_word = '0;
    hit = aligned;
    case (idx)
      IDX_SCAN_START: rd_word = {8'h00, scan_start_q};
      IDX_SCAN_END: rd_word = {8'h00, scan_end_q};
      IDX_SCAN_CTRL: rd_word = {24'h000000, scan_ctrl_q};
      IDX_SCAN_TRIG: rd_word = {24'h000000, scan_trig_q};
      IDX_DATA: rd_word = {16'h0000, data_q};
      IDX_ACC: rd_word = {16'h0000, acc_q};
      IDX_SHIFT: rd_word = {16'h0000, shifter_q};
      IDX_TAPS: rd_word = {16'h0000, taps_full};
      IDX_CTRL: begin
        rd_word[CTRL_EN_BIT] = en_q;
        rd_word[CTRL_GO_BIT] = go_q;
        rd_word[CTRL_BUSY_BIT] = busy_q;
        rd_word[CTRL_ZERO_AUGMENT_SELECT_BIT] = zero_augment_select_q;
        rd_word[CTRL_SHIFT_DIRECTION_SELECT_BIT] = shift_direction_select_q;
        rd_word[CTRL_FULL_BIT] = full_q;
      end
      IDX_LEN: rd_word = {24'h000000, len_q};
      default: hit = 1'b0;
    endcase
  end

  // apb answer: ready one cycle into the access phase
  always_comb begin
    pready_d = access && !pready_q;
    pslverr_d = access && !pready_q && !hit;
    prdata_d = prdata_q;
    if (access && !pready_q) begin
      prdata_d = (!PWRITE && hit) ? rd_word : '0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // configuration registers written by software
  always_comb begin
    en_d = en_q;
    go_d = go_q;
    zero_augment_select_d = zero_augment_select_q;
    shift_direction_select_d = shift_direction_select_q;
    len_d = len_q;
    taps_d = taps_q;
    scan_start_d = scan_start_q;
    scan_end_d = scan_end_q;
    scan_ctrl_d = scan_ctrl_q;
    scan_trig_d = scan_trig_q;
    if (wr_fire && aligned) begin
      case (idx)
        IDX_CTRL: begin
          if (PSTRB[0]) begin
            en_d = PWDATA[CTRL_EN_BIT];
            go_d = PWDATA[CTRL_GO_BIT];
            zero_augment_select_d = PWDATA[CTRL_ZERO_AUGMENT_SELECT_BIT];
            shift_direction_select_d = PWDATA[CTRL_SHIFT_DIRECTION_SELECT_BIT];
          end
        end
        IDX_LEN: len_d = wr_merged[7:0];
        IDX_TAPS: taps_d = wr_merged[15:1];
        IDX_SCAN_START: begin
          scan_start_d = wr_merged[23:0];
        end
        IDX_SCAN_END: begin
          scan_end_d = wr_merged[23:0];
        end
        IDX_SCAN_CTRL: begin
          if (PSTRB[0]) begin
            scan_ctrl_d = (scan_ctrl_q & ~SCAN_CTRL_WMASK)
              | (PWDATA[7:0] & SCAN_CTRL_WMASK);
          end
        end
        IDX_SCAN_TRIG: begin
          if (PSTRB[0]) begin
            scan_trig_d = PWDATA[7:0] & SCAN_TRIG_MASK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      en_q <= CTRL_RST[CTRL_EN_BIT];
      go_q <= CTRL_RST[CTRL_GO_BIT];
      zero_augment_select_q <= CTRL_RST[CTRL_ZERO_AUGMENT_SELECT_BIT];
      shift_direction_select_q <= CTRL_RST[CTRL_SHIFT_DIRECTION_SELECT_BIT];
      len_q <= LEN_RST;
      taps_q <= '0;
      scan_start_q <= SCAN_ADDR_RST;
      scan_end_q <= SCAN_ADDR_RST;
      scan_ctrl_q <= SCAN_CTRL_RST;
      scan_trig_q <= 8'h00;
    end else begin
      en_q <= en_d;
      go_q <= go_d;
      zero_augment_select_q <= zero_augment_select_d;
      shift_direction_select_q <= shift_direction_select_d;
      len_q <= len_d;
      taps_q <= taps_d;
      scan_start_q <= scan_start_d;
      scan_end_q <= scan_end_d;
      scan_ctrl_q <= scan_ctrl_d;
      scan_trig_q <= scan_trig_d;
    end
  end

  // shift engine: load, step, drain; software writes next, disable hold applied last
  always_comb begin
    state_d = state_q;
    full_d = full_q;
    shifter_d = shifter_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    data_d = data_q;
    case (state_q)
      ENG_OFF: begin
        if (en_q) begin
          state_d = ENG_IDLE;
        end
      end
      ENG_IDLE: begin
        if (go_q && full_q) begin
          shifter_d = data_q & dmask;
          cnt_d = {1'b0, data_width_minus_one} + 5'd1;
          full_d = 1'b0;
          state_d = ENG_SHIFT;
        end
      end
      ENG_SHIFT: begin
        if (go_q) begin
          acc_d = acc_step;
          shifter_d = shift_direction_select_q ? (shifter_q >> 1) : ((shifter_q << 1) & dmask);
          cnt_d = cnt_q - 5'd1;
          if (cnt_q == 5'd1) begin
            state_d = ENG_IDLE;
          end
        end
      end
      default: state_d = ENG_OFF;
    endcase
    // writes to the data word that strobe a low byte lane set full; set beats the load's clear
    if (wr_fire && aligned && (idx == IDX_DATA)) begin
      data_d = wr_merged[15:0];
      if (PSTRB[0] || PSTRB[1]) begin
        full_d = 1'b1;
      end
    end
    // software load of accumulator bytes wins over a step
    if (wr_fire && aligned && (idx == IDX_ACC)) begin
      acc_d = wr_merged[15:0];
    end
    // disabled engine is held in its internal reset, only data and accumulator writes and, in its first cycle, an ENG_SHIFT accumulator step still land
    if (!en_q) begin
      state_d = ENG_OFF;
      full_d = 1'b0;
      shifter_d = SHIFT_RST;
      cnt_d = '0;
    end
  end

  // status views derived from the next engine state
  always_comb begin
    busy_d = (state_d == ENG_SHIFT) || full_d;
    ready_d = en_d && go_d && !full_d;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_q <= ENG_OFF;
      full_q <= CTRL_RST[CTRL_FULL_BIT];
      shifter_q <= SHIFT_RST;
      cnt_q <= '0;
      acc_q <= ACC_RST;
      data_q <= DATA_RST;
      busy_q <= CTRL_RST[CTRL_BUSY_BIT];
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      full_q <= full_d;
      shifter_q <= shifter_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      data_q <= data_d;
      busy_q <= busy_d;
      ready_q <= ready_d;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign CRC_BUSY = busy_q;
  assign CRC_READY = ready_q;

endmodule

// *** verification/crce_top_asserts.sv ***
/* crce_top_asserts: port-level checker for crce_top.
   assumes apb on REF_CLK with one wait state and a sync high reset. */
`timescale 1ns/1ps
module crce_chk (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [crce_pkg::ADDR_W-1:0] PADDR,
  input wire logic [crce_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [crce_pkg::DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CRC_BUSY,
  input wire logic CRC_READY
);
  import crce_pkg::*;
  localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_DATA = {IDX_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] A_TAPS = {IDX_TAPS, 2'b00};
  localparam logic [ADDR_W-1:0] A_SHIFT = {IDX_SHIFT, 2'b00};
  logic en_q, en_d, go_q, go_d, ctrl_wr, data_wr;
  // completed writes seen on the bus
  assign ctrl_wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && PADDR == A_CTRL;
  assign data_wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && PADDR == A_DATA;
  // shadow of enable and start
  always_comb begin
    en_d = ctrl_wr ? PWDATA[CTRL_EN_BIT] : en_q;
    go_d = ctrl_wr ? PWDATA[CTRL_GO_BIT] : go_q;
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      en_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      en_q <= en_d;
      go_q <= go_d;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  chk_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("apb answer not after one wait state");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("pslverr without pready");
  chk_ready_needs_run: assert property (
    CRC_READY |-> en_q && go_q) else $error("ready while stopped");
  chk_off_quiet: assert property (
    !en_q && !$past(en_q) && !$past(en_q, 2) |-> !CRC_BUSY && !CRC_READY)
    else $error("disabled engine active");
  chk_data_busy: assert property (data_wr && en_q |=> ##[0:2] CRC_BUSY)
    else $error("no busy after data write");
  chk_busy_ends: assert property ($rose(CRC_BUSY) && go_q |-> ##[1:24] !CRC_BUSY)
    else $error("busy does not end");
  chk_full_ready: assert property (data_wr && en_q && go_q |=> ##[0:1] !CRC_READY)
    else $error("ready kept with full path");
  chk_refill: assert property (
    $fell(CRC_READY) && en_q && go_q |-> ##[1:20] CRC_READY) else $error("word not taken");
  chk_taps_bit0: assert property (
    PREADY && !PWRITE && !PSLVERR && PADDR == A_TAPS |-> PRDATA[0])
    else $error("tap bit zero not one");
  chk_shift_clear: assert property (
    PREADY && !PWRITE && PADDR == A_SHIFT && !en_q && !$past(en_q, 3) |-> PRDATA == 32'h0)
    else $error("shifter not clear when off");
  cover property (ctrl_wr && PWDATA[CTRL_GO_BIT]);
  cover property (PSLVERR);
  cover property ($fell(CRC_BUSY));
endmodule

bind crce_top crce_chk chk_i (.REF_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PSTRB, .PRDATA, .PREADY, .PSLVERR, .CRC_BUSY, .CRC_READY);

// *** verification/crce_top_bench.sv ***
/* crce_top_bench: register-level bench for crce_top over apb.
   assumes the checker is bound and one wait state per transfer. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module crce_top_bench;
  import crce_pkg::*;
  logic REF_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 16'h0000;
  logic [DATA_W-1:0] PWDATA = 32'h0, PRDATA, rv;
  logic [3:0] PSTRB = 4'h0;
  logic PREADY, PSLVERR, CRC_BUSY, CRC_READY, er;
  logic [15:0] ex, d;
  logic [7:0] c;
  int bad_count = 0, n_checks = 0, dl, pl;
  crce_top dut (.REF_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .CRC_BUSY, .CRC_READY);
  // 25 MHz clock
  always #20 REF_CLK = ~REF_CLK;
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled
  task automatic xfer(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] v,
                      input logic [3:0] s);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {i, 2'b00};
    PWDATA <= v;
    PSTRB <= s;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rv = PRDATA;
    er = PSLVERR;
    if (n >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] v);
    xfer(1'b1, i, v, 4'h3);
  endtask
  task automatic rd(input logic [IDX_W-1:0] i);
    xfer(1'b0, i, 32'h0, 4'h0);
  endtask
  // poll busy with a bound
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(IDX_CTRL);
      n++;
    end while (rv[CTRL_BUSY_BIT] !== 1'b0 && n < 12);
    if (n >= 12) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // reference accumulator step over one word
  function automatic logic [15:0] model(logic [15:0] a, logic [15:0] v, logic [15:0] t,
                                        int dw, int pw, logic am, logic sm);
    logic [15:0] mk;
    logic b, fb;
    mk = 16'((17'h1 << (pw + 1)) - 17'h1);
    for (int k = 0; k <= dw; k++) begin
      b = sm ? v[k] : v[dw - k];
      fb = am ? a[pw] ^ b : a[pw];
      a = am ? a << 1 : {a[14:0], b};
      a = (fb ? a ^ (t | 16'h0001) : a) & mk;
    end
    return a;
  endfunction
  // main sequence
  initial begin
    repeat (16) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    rd(IDX_CTRL); `CHK("ctrl rst", 32'h0, rv)
    rd(IDX_ACC); `CHK("acc rst", 32'h0, rv)
    rd(IDX_SHIFT); `CHK("shift rst", 32'h0, rv)
    rd(IDX_TAPS); `CHK("taps rst", 32'h1, rv)
    wr(IDX_DATA, 32'ha55a); rd(IDX_DATA); `CHK("data", 32'ha55a, rv)
    wr(IDX_SHIFT, 32'hffff); rd(IDX_SHIFT); `CHK("shift ro", 32'h0, rv)
    wr(IDX_ACC, 32'h1234);
    xfer(1'b1, IDX_ACC, 32'hab00, 4'h2); rd(IDX_ACC); `CHK("acc byte", 32'hab34, rv)
    rd(IDX_CTRL); `CHK("off full", 32'h0, rv)
    xfer(1'b0, 14'h0f51, 32'h0, 4'h0); `CHK("unmapped", 1'b1, er)
    // four modes, two lengths, two words each
    for (int m = 0; m < 4; m++) begin
      dl = m < 2 ? 7 : 3;
      pl = m < 2 ? 15 : 7;
      c = {1'b1, 2'b00, m[0], 2'b00, m[1], 1'b0};
      wr(IDX_LEN, {24'h0, dl[3:0], pl[3:0]});
      wr(IDX_TAPS, 32'h1021);
      wr(IDX_ACC, 32'h00ff);
      wr(IDX_CTRL, {24'h0, c});
      d = 16'h5ac3 ^ 16'(m);
      wr(IDX_DATA, {16'h0, d});
      rd(IDX_CTRL); `CHK("pending", {24'h0, c | 8'h21}, rv)
      `CHK("busy pin", 1'b1, CRC_BUSY)
      `CHK("ready pin", 1'b0, CRC_READY)
      ex = model(16'h00ff, d, 16'h1021, dl, pl, m[0], m[1]);
      wr(IDX_CTRL, {24'h0, c | 8'h40});
      wait_idle();
      d = ~d;
      wr(IDX_DATA, {16'h0, d});
      ex = model(ex, d, 16'h1021, dl, pl, m[0], m[1]);
      wait_idle(); `CHK("drained", {24'h0, c | 8'h40}, rv)
      `CHK("idle pin", 1'b0, CRC_BUSY)
      `CHK("take pin", 1'b1, CRC_READY)
      rd(IDX_ACC); `CHK("acc", {16'h0, ex}, rv)
    end
    wr(IDX_CTRL, 32'h0); rd(IDX_CTRL); `CHK("stop", 32'h0, rv)
    tally_and_finish();
  end
endmodule
